// ==== core/lasf_pkg.sv ====
/*
  constants, register map and carrier types for the limit-check register
  bank of a power monitor. assumes a byte-wide register access port driven
  by a serial-bus engine on the same clock.
*/
// Function
// - enable bit 7 arms power over-limit alert
// - enable bit 6 arms power under-limit alert
// - enable bits 5,4 arm sense over/under alerts
// - enable bits 3,2 arm supply over/under alerts
// - enable bits 1,0 arm auxiliary over/under alerts
// - all alert enables reset to zero
// - status bit 7 shows power above max threshold
// - status bit 6 shows power below min threshold
// - status bits 5,4 show sense limit state
// - status bits 3,2 show supply limit state
// - status bits 1,0 show auxiliary limit state
// - fault bit 7 latches power over-limit
// - fault bit 6 latches power under-limit
// - fault bits 5,4 latch sense limit events
// - fault bits 3,2 latch supply limit events
// - fault bits 1,0 latch auxiliary limit events
// - fault register read/write, status read-only
// - 12-bit high byte holds bits 11..4
// - 12-bit low byte bits 3..0, low nibble zero
// - power top byte holds bits 23..16
// - result/minmax writes need unlock; thresholds always
// - unlock bit halts conversion, resets cleared
package lasf_pkg;

  localparam int NCH  = 4;   // power, sense, supply, auxiliary
  localparam int NFLD = 5;   // value, max, min, max thresh, min thresh

  localparam logic [5:0] ADDR_CTRL       = 6'h00;
  localparam logic [5:0] ADDR_ALERT_EN   = 6'h01;
  localparam logic [5:0] ADDR_STATUS     = 6'h02;
  localparam logic [5:0] ADDR_FAULTS     = 6'h03;
  localparam logic [5:0] ADDR_POWER_BASE = 6'h05;
  localparam logic [5:0] ADDR_SENSE_BASE = 6'h14;
  localparam logic [5:0] ADDR_SUPPLY_BASE = 6'h1e;
  localparam logic [5:0] ADDR_AUX_BASE   = 6'h28;

  localparam int F_VAL   = 0;
  localparam int F_MAX   = 1;
  localparam int F_MIN   = 2;
  localparam int F_THMAX = 3;
  localparam int F_THMIN = 4;

  localparam int POWER_BYTES = 3;
  localparam int ADC_BYTES   = 2;
  localparam int TEST_BIT    = 4;

  localparam logic [7:0]  ALERT_EN_RST = 8'h00;
  localparam logic [7:0]  FAULTS_RST   = 8'h00;
  localparam logic [7:0]  CTRL_RST     = 8'h00;
  localparam logic [23:0] ZERO24       = 24'h000000;
  localparam logic [23:0] ONES_POWER   = 24'hffffff;
  localparam logic [23:0] ONES_ADC     = 24'h000fff;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lasf_req_t;

  typedef struct packed {
    logic        vld;
    logic [23:0] data;
  } lasf_sample_t;

endpackage : lasf_pkg

// ==== core/lasf_limit_regs.sv ====
/*
  limit-check register bank: alert enables, live limit status, sticky
  faults, and the result, min/max and threshold byte registers for power
  and three 12-bit channels. assumes the serial-bus engine presents single
  cycle read/write strobes, and the converter presents result pulses.
*/
`timescale 1ns/10ps
module lasf_limit_regs (
  input  wire logic                          clk,       // 100 MHz clock
  input  wire logic                          rst,       // async reset
  input  wire logic                          ce,        // clock enable
  input  wire lasf_pkg::lasf_req_t           req,       // register access
  input  wire lasf_pkg::lasf_sample_t [3:0]  sample,    // new results
  output logic [7:0]                         rdata,     // read byte
  output logic                               alert,     // alert level
  output logic                               conv_halt  // stop converter
);

  logic [7:0]  ctrl_q;
  logic [7:0]  alert_en_q;
  logic [7:0]  faults_q;
  logic [7:0]  faults_d;
  logic [7:0]  status;
  logic [7:0]  rdata_q;
  logic [7:0]  rdata_d;
  logic        alert_q;
  logic [23:0] fld_q [lasf_pkg::NCH][lasf_pkg::NFLD];
  logic [7:0]  ch_rd [lasf_pkg::NCH];
  logic        ch_hit [lasf_pkg::NCH];

  wire  [5:0]  addr6        = req.addr[5:0];   // top address bits ignored
  wire         test_unlock  = ctrl_q[lasf_pkg::TEST_BIT];
  wire         wr_ctrl      = req.wr && addr6 == lasf_pkg::ADDR_CTRL;
  wire         wr_alert_en  = req.wr && addr6 == lasf_pkg::ADDR_ALERT_EN;
  wire         wr_faults    = req.wr && addr6 == lasf_pkg::ADDR_FAULTS;

  function automatic logic [23:0] put_byte(input logic [23:0] old,
                                           input int          b,
                                           input logic        adc,
                                           input logic [7:0]  wd);
    logic [23:0] r;
    r = old;
    if (adc) begin
      if (b == 0) begin
        r[11:4] = wd;
      end else begin
        r[3:0] = wd[7:4];
      end
    end else begin
      r[23 - 8 * b -: 8] = wd;
    end
    return r;
  endfunction : put_byte

  function automatic logic [7:0] get_byte(input logic [23:0] v,
                                          input int          b,
                                          input logic        adc);
    logic [7:0] r;
    r = 8'h00;
    if (adc) begin
      if (b == 0) begin
        r = v[11:4];
      end else begin
        r = {v[3:0], 4'h0};
      end
    end else begin
      r = v[23 - 8 * b -: 8];
    end
    return r;
  endfunction : get_byte

  // per channel: byte decode, field storage, limit comparison
  for (genvar c = 0; c < lasf_pkg::NCH; c++) begin : g_ch
    localparam logic       ADC  = (c != 0);
    localparam int         NB   = ADC ? lasf_pkg::ADC_BYTES
                                      : lasf_pkg::POWER_BYTES;
    localparam logic [5:0] BASE = (c == 0) ? lasf_pkg::ADDR_POWER_BASE :
                                  (c == 1) ? lasf_pkg::ADDR_SENSE_BASE :
                                  (c == 2) ? lasf_pkg::ADDR_SUPPLY_BASE :
                                             lasf_pkg::ADDR_AUX_BASE;
    localparam logic [5:0] SPAN = 6'(lasf_pkg::NFLD * NB);
    localparam logic [23:0] ONES = ADC ? lasf_pkg::ONES_ADC
                                       : lasf_pkg::ONES_POWER;

    wire [5:0]  off   = addr6 - BASE;
    wire        hit   = addr6 >= BASE && off < SPAN;
    wire [5:0]  fidx  = off / 6'(NB);
    wire [5:0]  bidx  = off % 6'(NB);
    wire [23:0] smp   = ADC ? (sample[c].data & lasf_pkg::ONES_ADC)
                            : sample[c].data;
    // converter halted while unlocked, so new results are ignored
    wire        upd   = sample[c].vld && !test_unlock;
    wire [23:0] val   = fld_q[c][lasf_pkg::F_VAL];

    assign ch_hit[c] = hit;
    assign ch_rd[c]  = hit ? get_byte(fld_q[c][fidx[2:0]], int'(bidx), ADC)
                           : 8'h00;

    assign status[7 - 2 * c] = val > fld_q[c][lasf_pkg::F_THMAX];
    assign status[6 - 2 * c] = val < fld_q[c][lasf_pkg::F_THMIN];

    for (genvar f = 0; f < lasf_pkg::NFLD; f++) begin : g_fld
      localparam logic [23:0] RST =
        (f == lasf_pkg::F_MIN || f == lasf_pkg::F_THMAX) ? ONES
                                                         : lasf_pkg::ZERO24;
      localparam logic THRESH = (f >= lasf_pkg::F_THMAX);
      wire        fhit = hit && fidx == 6'(f);
      wire        we   = req.wr && fhit && (THRESH || test_unlock);
      logic [23:0] nxt;
      logic        take;

      always_comb begin
        nxt  = fld_q[c][f];
        take = 1'b0;
        if (f == lasf_pkg::F_VAL) begin
          nxt  = smp;
          take = upd;
        end else if (f == lasf_pkg::F_MAX) begin
          nxt  = smp;
          take = upd && smp > fld_q[c][f];
        end else if (f == lasf_pkg::F_MIN) begin
          nxt  = smp;
          take = upd && smp < fld_q[c][f];
        end
      end

      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          fld_q[c][f] <= RST;
        end else if (ce) begin
          if (we) begin
            fld_q[c][f] <= put_byte(fld_q[c][f], int'(bidx), ADC,
                                    req.wdata);
          end else if (take) begin
            fld_q[c][f] <= nxt;
          end
        end
      end
    end
  end

  // host write replaces the fault byte; live conditions still set
  assign faults_d = (wr_faults ? req.wdata : faults_q) | status;

  always_comb begin
    rdata_d = 8'h00;
    for (int c = 0; c < lasf_pkg::NCH; c++) begin
      rdata_d = rdata_d | ch_rd[c];
    end
    case (addr6)
      lasf_pkg::ADDR_CTRL:     rdata_d = ctrl_q;
      lasf_pkg::ADDR_ALERT_EN: rdata_d = alert_en_q;
      lasf_pkg::ADDR_STATUS:   rdata_d = status;
      lasf_pkg::ADDR_FAULTS:   rdata_d = faults_q;
      default:                 rdata_d = rdata_d;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_q     <= lasf_pkg::CTRL_RST;
      alert_en_q <= lasf_pkg::ALERT_EN_RST;
      faults_q   <= lasf_pkg::FAULTS_RST;
      rdata_q    <= 8'h00;
      alert_q    <= 1'b0;
    end else if (ce) begin
      if (wr_ctrl) begin
        ctrl_q <= req.wdata & (8'h01 << lasf_pkg::TEST_BIT);
      end
      if (wr_alert_en) begin
        alert_en_q <= req.wdata;
      end
      faults_q <= faults_d;
      if (req.rd) begin
        rdata_q <= rdata_d;
      end
      alert_q <= |(faults_q & alert_en_q);
    end
  end

  assign rdata     = rdata_q;
  assign alert     = alert_q;
  assign conv_halt = test_unlock;

endmodule : lasf_limit_regs

// ==== verif/lasf_limit_regs_asserts.sv ====
/* port checker for the limit-check bank.
   assumes it is bound to the bank and sees only its ports. */
`timescale 1ns/10ps
module lasf_limit_regs_chk (
  input wire logic                         clk,       // clock
  input wire logic                         rst,       // reset
  input wire logic                         ce,        // enable
  input wire lasf_pkg::lasf_req_t          req,       // access
  input wire lasf_pkg::lasf_sample_t [3:0] sample,    // results
  input wire logic [7:0]                   rdata,     // read byte
  input wire logic                         alert,     // alert
  input wire logic                         conv_halt  // halt
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire [5:0] a  = req.addr[5:0];
  wire       wr = ce & req.wr;
  wire       rd = ce & req.rd;
  halt_set_a: assert property (wr && a == 6'h00 |=>
    conv_halt == $past(req.wdata[4])) else $error("halt bit wrong");
  halt_hold_a: assert property (!(wr && a == 6'h00) |=>
    $stable(conv_halt)) else $error("halt moved");
  ctrl_read_a: assert property (rd && !wr && a == 6'h00 |=>
    rdata == {3'h0, conv_halt, 4'h0}) else $error("ctrl read wrong");
  rdata_hold_a: assert property (!rd |=> $stable(rdata))
    else $error("read byte moved");
  low_nibble_a: assert property (rd && a >= 6'h14 && a[0] |=>
    rdata[3:0] == 4'h0) else $error("low nibble set");
  enable_rb_a: assert property (wr && a == 6'h01 ##1
    rd && !wr && a == 6'h01 |=> rdata == $past(req.wdata, 2))
    else $error("enable readback wrong");
  fault_wr_a: assert property (wr && a == 6'h03 && req.wdata == 8'hff
    ##1 rd && !wr && a == 6'h03 |=> rdata == 8'hff)
    else $error("fault write lost");
  alert_off_a: assert property (wr && a == 6'h01 && req.wdata == 8'h00
    ##1 ce && !(wr && a == 6'h01) |=> !alert) else $error("alert stuck");
  cover property (alert);
  cover property (conv_halt && rd);
  cover property (sample[0].vld);
endmodule : lasf_limit_regs_chk

// ==== verif/lasf_conv_model.sv ====
/* converter stand-in: one result pulse per bench request while halt is low.
   assumes the bench names channel and value. */
`timescale 1ns/10ps
module lasf_conv_model (
  input  wire logic                    clk,    // clock
  input  wire logic                    go,     // send request
  input  wire logic [1:0]              ch,     // channel
  input  wire logic [23:0]             val,    // result
  input  wire logic                    halt,   // converter halt
  output lasf_pkg::lasf_sample_t [3:0] sample  // result pulses
);
  initial sample = '0;
  // data between results keeps changing so stale values are not trusted
  always @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      sample[i].vld  <= go && !halt && ch == i;
      sample[i].data <= (go && ch == i) ? val : ~sample[i].data;
    end
  end
endmodule : lasf_conv_model

// ==== verif/lasf_limit_regs_tb.sv ====
/* self-checking bench for the limit-check bank.
   assumes the converter stand-in and the bound port checker. */
`timescale 1ns/10ps
module lasf_limit_regs_tb;
  logic                         clk = 0, rst = 1, ce = 1, go = 0;
  logic                         alert, conv_halt;
  logic [1:0]                   ch = 0;
  logic [23:0]                  val = 0, v, last [4];
  logic [7:0]                   rdata, ta, en;
  logic [31:0]                  seed = 32'h00009f74;
  lasf_pkg::lasf_req_t          req = '0;
  lasf_pkg::lasf_sample_t [3:0] sample;
  int                           bad_count = 0, n_tests = 0, c, o;
  always #5 clk = ~clk;
  lasf_conv_model i_conv (.clk(clk), .go(go), .ch(ch), .val(val),
    .halt(conv_halt), .sample(sample));
  lasf_limit_regs i_dut (.clk(clk), .rst(rst), .ce(ce), .req(req),
    .sample(sample), .rdata(rdata), .alert(alert), .conv_halt(conv_halt));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [7:0] base(int c);
    return c == 0 ? 8'h05 : 8'h14 + 8'h0a * 8'(c - 1);
  endfunction : base
  function automatic logic [7:0] thr(int c, int o);
    return base(c) + (c == 0 ? (o ? 8'h09 : 8'h0c) : (o ? 8'h06 : 8'h08));
  endfunction : thr
  task automatic step(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic idle(int n);
    req = '0;
    step(n);
  endtask : idle
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(logic [7:0] a, logic [7:0] d);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    step(1);
  endtask : wr
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    step(1);
    chk(rdata, exp);
  endtask : rd
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  initial begin
    #1000000;
    bad_count++;
    end_of_test();
  end
  initial begin
    step(3);
    rst = 0;
    rd(8'h01, 8'h00);
    rd(8'h03, 8'h00);
    rd(8'h0e, 8'hff);
    for (int k = 0; k < 8; k++) begin
      c = 3 - k / 2;
      o = k % 2;
      ta = thr(c, o);
      v = 24'(rnd());
      if (c == 0) v = o ? v | 24'h010000 : v & 24'h7fffff;
      else v = o ? (v & 24'h0007ff) | 24'h000100 : v & 24'h0007ff;
      wr(ta, o ? 8'h00 : 8'hff);
      en = 8'(rnd()) & ~(8'h01 << k);
      wr(8'h01, en);
      wr(8'h03, 8'h00);
      go = 1;
      ch = 2'(c);
      val = v;
      last[c] = v;
      idle(1);
      go = 0;
      step(3);
      rd(8'h02, 8'h01 << k);
      rd(8'h03, 8'h01 << k);
      chk({7'h0, alert}, 8'h00);
      wr(8'h01, en | (8'h01 << k));
      idle(2);
      chk({7'h0, alert}, 8'h01);
      wr(ta, o ? 8'hff : 8'h00);
      rd(8'h02, 8'h00);
      rd(8'h03, 8'h01 << k);
      wr(8'h03, 8'h00);
      rd(8'h03, 8'h00);
      idle(1);
      chk({7'h0, alert}, 8'h00);
      rd(base(c), c == 0 ? v[23:16] : v[11:4]);
      if (c != 0) rd(base(c) + 8'h01, {v[3:0], 4'h0});
    end
    wr(8'h28, 8'h5a);
    rd(8'h28, last[3][11:4]);
    wr(8'h00, 8'hff);
    rd(8'h00, 8'h10);
    chk({7'h0, conv_halt}, 8'h01);
    wr(8'h28, 8'h5a);
    wr(8'h29, 8'hff);
    rd(8'h28, 8'h5a);
    rd(8'h29, 8'hf0);
    wr(8'h05, 8'h3c);
    rd(8'h05, 8'h3c);
    wr(8'h02, 8'hff);
    rd(8'h02, 8'h00);
    wr(8'h00, 8'h00);
    chk({7'h0, conv_halt}, 8'h00);
    wr(8'h03, 8'hff);
    rd(8'h03, 8'hff);
    wr(8'h01, 8'h00);
    rd(8'h01, 8'h00);
    idle(1);
    chk({7'h0, alert}, 8'h00);
    ce = 0;
    wr(8'h01, 8'hff);
    ce = 1;
    rd(8'h01, 8'h00);
    end_of_test();
  end
endmodule : lasf_limit_regs_tb
bind lasf_limit_regs lasf_limit_regs_chk i_chk (.clk(clk), .rst(rst),
  .ce(ce), .req(req), .sample(sample), .rdata(rdata), .alert(alert),
  .conv_halt(conv_halt));
